// >>> logic/gcr_decode.v
// How it works
// - Config word with bit 12 set is a null status-read command.
// - Null command ignores all lower bits; operation is unchanged.
// - Bit 11 zero selects device status out; one selects accumulator/position/speed.
// - With bit 11 set, bit 10 picks accumulator (0) or pointer info (1).
// - With bits 11 and 10 set, bit 9 picks position (0) or speed (1).
// - Bit 7 sets zero position side; a zeroing direction (bit 2) that differs is flagged as a mismatch.
// - Bit 6 picks 90 degree (0) or 60 degree (1) coil phasing.
// - Bit 5 zero enables air-core emulation; one gives constant acceleration.
// - Bit 4 picks calibration target: 1 MHz maximum (0) or nominal (1).
// - Bit 3 set starts internal clock calibration.
// - Calibration pulse follows on chip select; device times it.
// - Calibration accepted only when gauge disabled or pointer not moving.
// - Bit 2 set slows the oscillator period scaling to 0.66 of base.
// - Bit 0 enables the gauge output drivers.
// - Enable written zero enters standby; internal clock keeps running.
// - Velocity index 1 to 225 becomes maximum; larger values clamp to 225.
// - Faster motor steps down ramp at once to the new limit.
// - Velocity bit 8 must be set for a new maximum to apply.
// - Position word's twelve low bits give target 0 to 4095.
// - Zeroing uses full steps and integrates back-EMF into accumulator.
// - Zeroing bit 1 set with bit 0 clear starts; bit 1 clear stops.
// - Zeroing bit 4 picks stall-stop (0) or unconditional zeroing (1).
// - Zeroing bit 2 gives direction used to sequence the integrator.
`timescale 1ns/100ps
`default_nettype none
`include "gcr_regs.vh"

module gcr_decode (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_word_valid,
  input wire [15:0] i_word,
  input wire i_pointer_moving,
  input wire i_cur_vel_above,
  output reg [1:0] o_so_select,
  output reg o_zero_side_cw,
  output reg o_phase_60,
  output reg o_aircore_off,
  output reg o_calib_nominal,
  output reg o_calib_start,
  output reg o_osc_slow,
  output reg o_drive_enable,
  output reg o_standby,
  output reg [7:0] o_velocity_index,
  output reg o_velocity_step_down,
  output reg [11:0] o_pointer_target,
  output reg o_target_load,
  output reg o_zeroing_active,
  output reg o_zeroing_uncond,
  output reg o_zeroing_dir_cw,
  output reg o_zero_side_mismatch
);

  // ----------------------------------------------------------------
  // Word decode
  // ----------------------------------------------------------------
  wire [2:0] addr = i_word[`GCR_ADDR_HI:`GCR_ADDR_LO];
  wire cfg_wr = i_word_valid && (addr == `GCR_ADDR_CFG) && !i_word[`GCR_CFG_NULL];
  wire vel_wr = i_word_valid && (addr == `GCR_ADDR_VEL) && i_word[`GCR_VEL_UPD];
  wire pos_wr = i_word_valid && (addr == `GCR_ADDR_POS);
  wire rtz_wr = i_word_valid && (addr == `GCR_ADDR_RTZ) && !i_word[`GCR_RTZ_ZERO];
  wire [7:0] vel_raw = i_word[7:0];
  // A zero index has no ramp entry, so it is raised to the first one.
  wire [7:0] vel_clamped = (vel_raw > `GCR_VEL_MAX) ? `GCR_VEL_MAX :
                           (vel_raw < `GCR_VEL_MIN) ? `GCR_VEL_MIN : vel_raw;
  reg [1:0] so_sel_next;

  always @* begin
    if (!i_word[`GCR_CFG_STSEL]) begin
      so_sel_next = `GCR_SO_STATUS;
    end else if (!i_word[`GCR_CFG_ACCSEL]) begin
      so_sel_next = `GCR_SO_ACCUM;
    end else if (!i_word[`GCR_CFG_SPDSEL]) begin
      so_sel_next = `GCR_SO_POS;
    end else begin
      so_sel_next = `GCR_SO_SPEED;
    end
  end

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_so_select <= `GCR_SO_STATUS;
      o_zero_side_cw <= 1'b0;
      o_phase_60 <= 1'b0;
      o_aircore_off <= 1'b0;
      o_calib_nominal <= 1'b0;
      o_calib_start <= 1'b0;
      o_osc_slow <= 1'b0;
      o_drive_enable <= 1'b0;
      o_standby <= 1'b1;
    end else begin
      o_calib_start <= 1'b0;
      if (cfg_wr) begin
        o_so_select <= so_sel_next;
        o_zero_side_cw <= i_word[`GCR_CFG_ZSIDE];
        o_phase_60 <= i_word[`GCR_CFG_PHASE];
        o_aircore_off <= i_word[`GCR_CFG_ACOFF];
        o_calib_nominal <= i_word[`GCR_CFG_FREQ];
        o_osc_slow <= i_word[`GCR_CFG_SLOW];
        o_drive_enable <= i_word[`GCR_CFG_EN];
        o_standby <= !i_word[`GCR_CFG_EN];
        // Enable state judged before this write; a moving pointer refuses it only while the gauge is enabled.
        o_calib_start <= i_word[`GCR_CFG_CAL] &&
                         (!o_drive_enable || !i_pointer_moving);
      end
    end
  end

  // ----------------------------------------------------------------
  // Velocity, position and zeroing registers
  // ----------------------------------------------------------------
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_velocity_index <= `GCR_VEL_RST;
      o_velocity_step_down <= 1'b0;
      o_pointer_target <= 12'h000;
      o_target_load <= 1'b0;
      o_zeroing_active <= 1'b0;
      o_zeroing_uncond <= 1'b0;
      o_zeroing_dir_cw <= 1'b0;
      o_zero_side_mismatch <= 1'b0;
    end else begin
      o_target_load <= 1'b0;
      if (vel_wr) begin
        o_velocity_index <= vel_clamped;
      end
      // Held until the ramp reports the speed is at or under the limit.
      o_velocity_step_down <= i_cur_vel_above;
      if (pos_wr) begin
        o_pointer_target <= i_word[11:0];
        o_target_load <= 1'b1;
      end
      if (rtz_wr) begin
        o_zeroing_active <= i_word[`GCR_RTZ_EN];
        o_zeroing_uncond <= i_word[`GCR_RTZ_UNCOND];
        o_zeroing_dir_cw <= i_word[`GCR_RTZ_DIR];
        o_zero_side_mismatch <= i_word[`GCR_RTZ_DIR] ^ o_zero_side_cw;
      end
    end
  end

endmodule
`default_nettype wire

// >>> logic/gcr_regs.vh
`ifndef GCR_REGS_VH
`define GCR_REGS_VH

`define GCR_ADDR_CFG 3'h0
`define GCR_ADDR_VEL 3'h1
`define GCR_ADDR_POS 3'h2
`define GCR_ADDR_RTZ 3'h4
`define GCR_ADDR_HI 15
`define GCR_ADDR_LO 13

`define GCR_CFG_NULL 12
`define GCR_CFG_STSEL 11
`define GCR_CFG_ACCSEL 10
`define GCR_CFG_SPDSEL 9
`define GCR_CFG_ZSIDE 7
`define GCR_CFG_PHASE 6
`define GCR_CFG_ACOFF 5
`define GCR_CFG_FREQ 4
`define GCR_CFG_CAL 3
`define GCR_CFG_SLOW 2
`define GCR_CFG_EN 0

`define GCR_VEL_UPD 8
`define GCR_VEL_MAX 8'hE1
`define GCR_VEL_MIN 8'h01
`define GCR_VEL_RST 8'hE1

`define GCR_RTZ_UNCOND 4
`define GCR_RTZ_DIR 2
`define GCR_RTZ_EN 1
`define GCR_RTZ_ZERO 0

`define GCR_SO_STATUS 2'h0
`define GCR_SO_ACCUM 2'h1
`define GCR_SO_POS 2'h2
`define GCR_SO_SPEED 2'h3

`endif

// >>> verification/gcr_decode_props.sv
`timescale 1ns/100ps
`default_nettype none
module gcr_decode_props(
  input wire i_core_clk, i_rst, i_word_valid, i_pointer_moving, i_cur_vel_above,
  input wire [15:0] i_word,
  input wire [1:0] o_so_select,
  input wire o_calib_start, o_drive_enable, o_standby, o_velocity_step_down,
  input wire o_target_load, o_zeroing_active, o_zeroing_uncond,
  input wire [7:0] o_velocity_index,
  input wire [11:0] o_pointer_target
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  wire [2:0] ad = i_word[15:13];
  wire [1:0] so_exp = !i_word[11] ? 2'h0 : !i_word[10] ? 2'h1 : {1'b1, i_word[9]};
  wire [7:0] vi = i_word[7:0];
  wire [7:0] v_exp = vi > 8'hE1 ? 8'hE1 : vi == 8'h00 ? 8'h01 : vi;
  wire cal_ok = i_word[3] && !(o_drive_enable && i_pointer_moving);
  sequence s_cfg; i_word_valid && ad == 3'h0 && !i_word[12]; endsequence
  sequence s_vel; i_word_valid && ad == 3'h1; endsequence
  drive_en_a: assert property (s_cfg |=> o_drive_enable == $past(i_word[0]) && o_standby != o_drive_enable)
    else $error("drive enable wrong");
  null_hold_a: assert property (i_word_valid && ad == 3'h0 && i_word[12] |=> $stable(o_so_select))
    else $error("null command changed state");
  so_sel_a: assert property (s_cfg |=> o_so_select == $past(so_exp))
    else $error("serial-out select wrong");
  vel_clamp_a: assert property (s_vel ##0 i_word[8] |=> o_velocity_index == $past(v_exp))
    else $error("velocity index wrong");
  vel_hold_a: assert property (s_vel ##0 !i_word[8] |=> $stable(o_velocity_index))
    else $error("velocity changed without update bit");
  pos_load_a: assert property (i_word_valid && ad == 3'h2 |=> o_target_load && o_pointer_target == $past(i_word[11:0]))
    else $error("target not loaded");
  cal_start_a: assert property (s_cfg ##0 cal_ok |=> o_calib_start)
    else $error("calibration not started");
  rtz_cmd_a: assert property (i_word_valid && ad == 3'h4 && !i_word[0] |=> o_zeroing_active == $past(i_word[1]))
    else $error("zeroing enable wrong");
  step_down_a: assert property (i_cur_vel_above |=> o_velocity_step_down)
    else $error("step down missing");
endmodule
bind gcr_decode gcr_decode_props u_props(.*);
`default_nettype wire

// >>> verification/gcr_decode_tb.sv
`timescale 1ns/100ps
`default_nettype none
module gcr_decode_tb;
  logic clk = 0, rst = 1, go = 0, mov = 0, above = 0, v;
  logic [15:0] raw = 16'h0000, w;
  wire [1:0] sel;
  wire en, sb, cal, ld, za, zu, sd, zs, ph, ac, cn, os, zd, zm;
  wire [7:0] vi;
  wire [11:0] tg;
  integer error_cnt = 0, n_checks = 0, seed = 32'hedd9, i, m_en = 0, m_sel = 0;
  integer m_vi = 225, m_tg = 0, m_z = 0, e_cal, m_cfg = 0, m_zd = 0, m_zm = 0;
  initial forever #5 clk = ~clk;
  gcr_host host(.i_go(go), .i_raw(raw), .o_valid(v), .o_word(w));
  gcr_decode dut(.i_core_clk(clk), .i_rst(rst), .i_word_valid(v), .i_word(w),
    .i_pointer_moving(mov), .i_cur_vel_above(above), .o_so_select(sel), .o_zero_side_cw(zs),
    .o_phase_60(ph), .o_aircore_off(ac), .o_calib_nominal(cn), .o_calib_start(cal),
    .o_osc_slow(os),
    .o_drive_enable(en), .o_standby(sb), .o_velocity_index(vi), .o_velocity_step_down(sd),
    .o_pointer_target(tg), .o_target_load(ld), .o_zeroing_active(za), .o_zeroing_uncond(zu),
    .o_zeroing_dir_cw(zd), .o_zero_side_mismatch(zm));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("errors=%0d checks=%0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    end_of_test;
  end
  initial begin
    repeat (12) @(negedge clk);
    rst = 0;
    chk(vi, 225);
    chk(sb, 1);
    for (i = 0; i < 600; i++) begin
      @(negedge clk);
      raw = $random(seed);
      {mov, above} = $random(seed);
      go = 1;
      #1;
      e_cal = 0;
      case (w[15:13])
        3'h0: if (!w[12]) begin
          e_cal = w[3] && !(m_en && mov);
          m_en = w[0];
          m_cfg = {w[7], w[6], w[5], w[4], w[2]};
          m_sel = !w[11] ? 0 : !w[10] ? 1 : 2 + w[9];
        end
        3'h1: if (w[8]) m_vi = w[7:0] > 225 ? 225 : w[7:0] == 0 ? 1 : w[7:0];
        3'h2: m_tg = w[11:0];
        3'h4: if (!w[0]) begin
          m_z = w[1] * 2 + w[4];
          m_zd = w[2];
          m_zm = w[2] ^ m_cfg[4];
        end
        default: ;
      endcase
      @(negedge clk);
      go = 0;
      chk(cal, e_cal);
      chk(ld, w[15:13] == 3'h2);
      chk(sd, above);
      chk(en, m_en);
      chk(sb, !m_en);
      chk(sel, m_sel);
      chk(vi, m_vi);
      chk(tg, m_tg);
      chk({za, zu}, m_z);
      chk({zs, ph, ac, cn, os}, m_cfg);
      chk(zd, m_zd);
      chk(zm, m_zm);
    end
    end_of_test;
  end
endmodule
`default_nettype wire

// >>> verification/gcr_host.sv
`timescale 1ns/100ps
`default_nettype none
module gcr_host(
  input wire logic i_go,
  input wire logic [15:0] i_raw,
  output logic o_valid,
  output logic [15:0] o_word
);
  // Zeroing bit 0 is left random on purpose so that refused writes occur.
  always_comb begin
    o_valid = i_go;
    case (i_raw[15:13])
      3'h0: o_word = i_raw & 16'hFEFD;
      3'h1: o_word = i_raw & 16'hE1FF;
      3'h2: o_word = i_raw & 16'hEFFF;
      3'h4: o_word = i_raw & 16'h8017;
      default: o_word = i_raw;
    endcase
  end
endmodule
`default_nettype wire
